// File: rtl/gpr_bank.sv
/*
  Register bank of a three-port GPIO block: pull-up, output data, direction
  and pin input registers per port, plus the switch guard control register.
  Assumes a byte-wide register port on the system clock with one-cycle
  strobes, and pins that are resolved from out/oe_n outside this block.
*/
`timescale 1ns/1ps
`default_nettype none

`include "gpr_defs.svh"

// Behaviour
// - switch guard control bits 7 to 3 always read as zero
// - control bit 2 guards third-port pins made output by a direction write
// - guarded pin made output stays tri-stated for one extra cycle first
// - control bit 1 guards second-port pins made output by a direction write
// - control bit 0 guards first-port pins made output by a direction write
// - first-port pull-up enables, eight bits, read-write at 0x12, reset zero
// - first-port output data, eight bits, read-write at 0x11, reset zero
// - first-port direction, eight bits, read-write at 0x10, reset zero
// - first-port pin input register at 0x0F reflects the pin levels
module gpr_bank
  import gpr_pkg::*;
(
  input wire logic clk_i, // system clock, 250 MHz
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [5:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after rd_i
  input wire logic [7:0] pa_pin_i, // port a pin levels
  output logic [7:0] pa_out_o, // port a output levels
  output logic [7:0] pa_oe_n_o, // port a enables, low drives
  output logic [7:0] pa_pullup_o, // port a pull-ups on
  input wire logic [3:0] pb_pin_i, // port b pin levels
  output logic [3:0] pb_out_o, // port b output levels
  output logic [3:0] pb_oe_n_o, // port b enables, low drives
  output logic [3:0] pb_pullup_o, // port b pull-ups on
  input wire logic [5:0] pc_pin_i, // port c pin levels
  output logic [5:0] pc_out_o, // port c output levels
  output logic [5:0] pc_oe_n_o, // port c enables, low drives
  output logic [5:0] pc_pullup_o // port c pull-ups on
);

  // one address comparison, shared by the read and write decoders
  function automatic logic gpr_hit(input gpr_addr_t a, input gpr_addr_t ofs);
    gpr_hit = (a == ofs);
  endfunction

  // software-visible state
  gpr_pa_t pa_pue_q;
  gpr_pa_t pa_data_q;
  gpr_pa_t pa_dir_q;
  gpr_pb_t pb_pue_q;
  gpr_pb_t pb_data_q;
  gpr_pb_t pb_dir_q;
  gpr_pc_t pc_pue_q;
  gpr_pc_t pc_data_q;
  gpr_pc_t pc_dir_q;
  gpr_ctrl_t ctrl_q;
  gpr_byte_t rdata_q;
  gpr_byte_t rdata_d;

  // next values
  gpr_pa_t pa_pue_d;
  gpr_pa_t pa_data_d;
  gpr_pa_t pa_dir_d;
  gpr_pb_t pb_pue_d;
  gpr_pb_t pb_data_d;
  gpr_pb_t pb_dir_d;
  gpr_pc_t pc_pue_d;
  gpr_pc_t pc_data_d;
  gpr_pc_t pc_dir_d;
  gpr_ctrl_t ctrl_d;

  // synchronised pin levels from the pin drivers
  gpr_pa_t pa_sync_w;
  gpr_pb_t pb_sync_w;
  gpr_pc_t pc_sync_w;

  // address decode
  wire sel_ctrl = gpr_hit(addr_i, `GPR_OFS_GUARD_CTRL);
  wire sel_pa_pue = gpr_hit(addr_i, `GPR_OFS_PA_PULLUP);
  wire sel_pa_data = gpr_hit(addr_i, `GPR_OFS_PA_DATA);
  wire sel_pa_dir = gpr_hit(addr_i, `GPR_OFS_PA_DIR);
  wire sel_pa_pin = gpr_hit(addr_i, `GPR_OFS_PA_PIN);
  wire sel_pb_pue = gpr_hit(addr_i, `GPR_OFS_PB_PULLUP);
  wire sel_pb_data = gpr_hit(addr_i, `GPR_OFS_PB_DATA);
  wire sel_pb_dir = gpr_hit(addr_i, `GPR_OFS_PB_DIR);
  wire sel_pb_pin = gpr_hit(addr_i, `GPR_OFS_PB_PIN);
  wire sel_pc_pue = gpr_hit(addr_i, `GPR_OFS_PC_PULLUP);
  wire sel_pc_data = gpr_hit(addr_i, `GPR_OFS_PC_DATA);
  wire sel_pc_dir = gpr_hit(addr_i, `GPR_OFS_PC_DIR);
  wire sel_pc_pin = gpr_hit(addr_i, `GPR_OFS_PC_PIN);

  // write strobes per register
  wire wr_ctrl = wr_i & sel_ctrl;
  wire wr_pa_pue = wr_i & sel_pa_pue;
  wire wr_pa_data = wr_i & sel_pa_data;
  wire wr_pa_dir = wr_i & sel_pa_dir;
  wire wr_pa_pin = wr_i & sel_pa_pin;
  wire wr_pb_pue = wr_i & sel_pb_pue;
  wire wr_pb_data = wr_i & sel_pb_data;
  wire wr_pb_dir = wr_i & sel_pb_dir;
  wire wr_pb_pin = wr_i & sel_pb_pin;
  wire wr_pc_pue = wr_i & sel_pc_pue;
  wire wr_pc_data = wr_i & sel_pc_data;
  wire wr_pc_dir = wr_i & sel_pc_dir;
  wire wr_pc_pin = wr_i & sel_pc_pin;

  // per-port guard enables taken from the control register
  wire guard_a_w = ctrl_q[`GPR_CTRL_GUARD_A];
  wire guard_b_w = ctrl_q[`GPR_CTRL_GUARD_B];
  wire guard_c_w = ctrl_q[`GPR_CTRL_GUARD_C];

  // first port: full byte registers; a one written to the pin register
  // toggles the output data bit, so software can flip a pin in one write
  assign pa_pue_d = wr_pa_pue ? wdata_i : pa_pue_q;
  assign pa_dir_d = wr_pa_dir ? wdata_i : pa_dir_q;
  assign pa_data_d = wr_pa_data ? wdata_i
                   : wr_pa_pin ? (pa_data_q ^ wdata_i)
                   : pa_data_q;

  // second and third ports keep only their implemented bits, so the
  // upper write data bits are simply dropped
  assign pb_pue_d = wr_pb_pue ? wdata_i[3:0] : pb_pue_q;
  assign pb_dir_d = wr_pb_dir ? wdata_i[3:0] : pb_dir_q;
  assign pb_data_d = wr_pb_data ? wdata_i[3:0]
                   : wr_pb_pin ? (pb_data_q ^ wdata_i[3:0])
                   : pb_data_q;
  assign pc_pue_d = wr_pc_pue ? wdata_i[5:0] : pc_pue_q;
  assign pc_dir_d = wr_pc_dir ? wdata_i[5:0] : pc_dir_q;
  assign pc_data_d = wr_pc_data ? wdata_i[5:0]
                   : wr_pc_pin ? (pc_data_q ^ wdata_i[5:0])
                   : pc_data_q;

  // only the three guard bits exist; the reserved ones hold nothing
  assign ctrl_d = wr_ctrl ? wdata_i[2:0] : ctrl_q;

  // read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    rdata_d = `GPR_RDATA_IDLE;
    if (!rd_i)
      rdata_d = `GPR_RDATA_IDLE;
    else if (sel_ctrl)
      rdata_d = {5'h00, ctrl_q};
    else if (sel_pa_pue)
      rdata_d = pa_pue_q;
    else if (sel_pa_data)
      rdata_d = pa_data_q;
    else if (sel_pa_dir)
      rdata_d = pa_dir_q;
    else if (sel_pa_pin)
      rdata_d = pa_sync_w;
    else if (sel_pb_pue)
      rdata_d = {4'h0, pb_pue_q};
    else if (sel_pb_data)
      rdata_d = {4'h0, pb_data_q};
    else if (sel_pb_dir)
      rdata_d = {4'h0, pb_dir_q};
    else if (sel_pb_pin)
      rdata_d = {4'h0, pb_sync_w};
    else if (sel_pc_pue)
      rdata_d = {2'h0, pc_pue_q};
    else if (sel_pc_data)
      rdata_d = {2'h0, pc_data_q};
    else if (sel_pc_dir)
      rdata_d = {2'h0, pc_dir_q};
    else if (sel_pc_pin)
      rdata_d = {2'h0, pc_sync_w};
  end

  // first port registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pa_pue_q <= `GPR_RST_PA;
      pa_data_q <= `GPR_RST_PA;
      pa_dir_q <= `GPR_RST_PA;
    end
    else
    begin
      pa_pue_q <= pa_pue_d;
      pa_data_q <= pa_data_d;
      pa_dir_q <= pa_dir_d;
    end
  end

  // second port registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pb_pue_q <= `GPR_RST_PB;
      pb_data_q <= `GPR_RST_PB;
      pb_dir_q <= `GPR_RST_PB;
    end
    else
    begin
      pb_pue_q <= pb_pue_d;
      pb_data_q <= pb_data_d;
      pb_dir_q <= pb_dir_d;
    end
  end

  // third port registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pc_pue_q <= `GPR_RST_PC;
      pc_data_q <= `GPR_RST_PC;
      pc_dir_q <= `GPR_RST_PC;
    end
    else
    begin
      pc_pue_q <= pc_pue_d;
      pc_data_q <= pc_data_d;
      pc_dir_q <= pc_dir_d;
    end
  end

  // control and read data; read data fall back to zero after one cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= `GPR_RST_CTRL;
      rdata_q <= `GPR_RDATA_IDLE;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // pin drivers; every output below comes from a flop inside them
  gpr_port_pins #(.W(8)) u_pins_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .guard_en_i(guard_a_w),
    .dir_i(pa_dir_q),
    .data_i(pa_data_q),
    .pue_i(pa_pue_q),
    .pin_i(pa_pin_i),
    .pin_sync_o(pa_sync_w),
    .out_o(pa_out_o),
    .oe_n_o(pa_oe_n_o),
    .pullup_o(pa_pullup_o)
  );

  gpr_port_pins #(.W(4)) u_pins_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .guard_en_i(guard_b_w),
    .dir_i(pb_dir_q),
    .data_i(pb_data_q),
    .pue_i(pb_pue_q),
    .pin_i(pb_pin_i),
    .pin_sync_o(pb_sync_w),
    .out_o(pb_out_o),
    .oe_n_o(pb_oe_n_o),
    .pullup_o(pb_pullup_o)
  );

  gpr_port_pins #(.W(6)) u_pins_c (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .guard_en_i(guard_c_w),
    .dir_i(pc_dir_q),
    .data_i(pc_data_q),
    .pue_i(pc_pue_q),
    .pin_i(pc_pin_i),
    .pin_sync_o(pc_sync_w),
    .out_o(pc_out_o),
    .oe_n_o(pc_oe_n_o),
    .pullup_o(pc_pullup_o)
  );

  // bits that a direction write turns from input to output
  wire [5:0] pc_turn_w = wdata_i[5:0] & ~pc_dir_q;
  wire [3:0] pb_turn_w = wdata_i[3:0] & ~pb_dir_q;

  // a direction write on a guarded port that turns pins into outputs
  sequence s_pc_turn_on;
    wr_pc_dir && guard_c_w && (pc_turn_w != 6'h00);
  endsequence

  sequence s_pb_turn_on;
    wr_pb_dir && guard_b_w && (pb_turn_w != 4'h0);
  endsequence

  sequence s_pa_turn_on;
    wr_pa_dir && guard_a_w && ((wdata_i & ~pa_dir_q) != 8'h00);
  endsequence

  a_pc_guard_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_pc_turn_on |-> ##2 ((pc_oe_n_o & $past(pc_turn_w, 2)) == $past(pc_turn_w, 2)))
    else $error("third port pin driven without tri-state cycle");

  a_pb_guard_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_pb_turn_on |-> ##2 ((pb_oe_n_o & $past(pb_turn_w, 2)) == $past(pb_turn_w, 2)))
    else $error("second port pin driven without tri-state cycle");

  a_pa_guard_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_pa_turn_on ##1 (!wr_pa_dir)[*2] |-> ##1 ((pa_oe_n_o & pa_dir_q) == 8'h00))
    else $error("first port pin not driven after the tri-state cycle");

  a_ctrl_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_ctrl) |=> (rdata_o[7:3] == 5'h00) && (rdata_o[2:0] == $past(ctrl_q)))
    else $error("guard control reserved bits not zero");

  a_pa_pue_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pa_pue ##1 (rd_i && sel_pa_pue) |=> (rdata_o == $past(wdata_i, 2)))
    else $error("first port pull-up readback wrong");

  a_pa_data_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pa_data |=> ##1 (pa_out_o == $past(wdata_i, 2)))
    else $error("first port output data not on pins");

  a_pa_dir_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_pa_dir |=> (pa_dir_q == $past(wdata_i)))
    else $error("first port direction not stored");

  a_reset_clear: assert property (@(posedge clk_i)
    !rst_n_i |=> (pa_pue_q == 8'h00) && (pa_data_q == 8'h00) && (pa_dir_q == 8'h00))
    else $error("first port registers not cleared by reset");

  a_pa_pin_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && sel_pa_pin) |=> (rdata_o == $past(pa_sync_w)))
    else $error("first port pin read does not show pin levels");

  a_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && (sel_pb_dir || sel_pb_data || sel_pb_pue || sel_pb_pin)) |=> (rdata_o[7:4] == 4'h0))
    else $error("second port upper bits not zero");

endmodule

`default_nettype wire

// File: rtl/gpr_defs.svh
/*
  Register offsets, control bit positions and reset values of the three-port
  GPIO register bank. Assumes a byte-wide register port with 6-bit addresses.
*/
`ifndef GPR_DEFS_SVH
`define GPR_DEFS_SVH

// register offsets on the plain register port
`define GPR_OFS_GUARD_CTRL 6'h01
`define GPR_OFS_PC_PIN 6'h07
`define GPR_OFS_PC_DIR 6'h08
`define GPR_OFS_PC_DATA 6'h09
`define GPR_OFS_PC_PULLUP 6'h0A
`define GPR_OFS_PB_PIN 6'h0B
`define GPR_OFS_PB_DIR 6'h0C
`define GPR_OFS_PB_DATA 6'h0D
`define GPR_OFS_PB_PULLUP 6'h0E
`define GPR_OFS_PA_PIN 6'h0F
`define GPR_OFS_PA_DIR 6'h10
`define GPR_OFS_PA_DATA 6'h11
`define GPR_OFS_PA_PULLUP 6'h12

// switch guard control bit positions
`define GPR_CTRL_GUARD_A 0
`define GPR_CTRL_GUARD_B 1
`define GPR_CTRL_GUARD_C 2

// reset values
`define GPR_RST_PA 8'h00
`define GPR_RST_PB 4'h0
`define GPR_RST_PC 6'h00
`define GPR_RST_CTRL 3'h0
`define GPR_RDATA_IDLE 8'h00

`endif

// File: rtl/gpr_pkg.sv
/*
  Types shared by the GPIO register bank and its testbench.
  Assumes the definitions header is compiled alongside.
*/
package gpr_pkg;
  typedef logic [5:0] gpr_addr_t;
  typedef logic [7:0] gpr_byte_t;
  typedef logic [7:0] gpr_pa_t;
  typedef logic [3:0] gpr_pb_t;
  typedef logic [5:0] gpr_pc_t;
  typedef logic [2:0] gpr_ctrl_t;
endpackage

// File: rtl/gpr_port_pins.sv
/*
  Pin side of one GPIO port: input synchroniser, registered output data,
  output enable with the switch guard gap, and pull-up request.
  Assumes direction, data and pull-up come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gpr_port_pins
#(
  parameter int W = 8
)
(
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic guard_en_i, // switch guard enabled for this port
  input wire logic [W-1:0] dir_i, // direction, 1 = output
  input wire logic [W-1:0] data_i, // output data
  input wire logic [W-1:0] pue_i, // pull-up enables
  input wire logic [W-1:0] pin_i, // pin levels, asynchronous
  output logic [W-1:0] pin_sync_o, // synchronised pin levels
  output logic [W-1:0] out_o, // pin output level
  output logic [W-1:0] oe_n_o, // output enable, low drives
  output logic [W-1:0] pullup_o // pull-up on
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] dir_seen_q;
  logic [W-1:0] out_q;
  logic [W-1:0] oe_n_q;
  logic [W-1:0] pull_q;
  wire [W-1:0] guard_w;
  wire [W-1:0] drive_w;

  // a pin newly made output is held off one cycle so it never fights
  // the far side while both ends swap roles
  assign guard_w = {W{guard_en_i}} & dir_i & ~dir_seen_q;
  assign drive_w = dir_i & ~guard_w;

  // pins reset tri-stated; sync stages only feed each other
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
      dir_seen_q <= '0;
      out_q <= '0;
      oe_n_q <= '1;
      pull_q <= '0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      dir_seen_q <= dir_i;
      out_q <= data_i;
      oe_n_q <= ~drive_w;
      pull_q <= pue_i & ~drive_w; // pull-up only useful on an input
    end
  end

  assign pin_sync_o = sync_q;
  assign out_o = out_q;
  assign oe_n_o = oe_n_q;
  assign pullup_o = pull_q;

  // per-bit checks of the guard gap and the drive rule
  for (genvar i = 0; i < W; i++)
  begin : g_chk
    a_guard_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (guard_en_i && $rose(dir_i[i])) |=> oe_n_o[i])
      else $error("pin drove without the guard cycle");
    a_no_guard_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (!guard_en_i && $rose(dir_i[i])) |=> !oe_n_o[i])
      else $error("pin not driven one cycle after direction set");
    a_input_undriven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !dir_i[i] |=> oe_n_o[i])
      else $error("pin driven while direction is input");
  end

endmodule

`default_nettype wire

// File: tb/gpr_bank_test.sv
/*
  Self-checking testbench of the three-port GPIO register bank.
  Assumes the bank's byte-wide register port, its pin ports and the
  offsets of the definitions header; the pins are driven here directly.
*/
`timescale 1ns/1ps
`default_nettype none

`include "gpr_defs.svh"

module gpr_bank_test;
  import gpr_pkg::*;

  logic clk_i;
  logic rst_n_i;
  logic [5:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic [7:0] pa_pin_i, pa_out_o, pa_oe_n_o, pa_pullup_o;
  logic [3:0] pb_pin_i, pb_out_o, pb_oe_n_o, pb_pullup_o;
  logic [5:0] pc_pin_i, pc_out_o, pc_oe_n_o, pc_pullup_o;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 32'hcfbc71a0;
  logic [7:0] exp_reg [64];

  gpr_bank i_gpr_bank (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pa_pin_i(pa_pin_i), .pa_out_o(pa_out_o), .pa_oe_n_o(pa_oe_n_o), .pa_pullup_o(pa_pullup_o),
    .pb_pin_i(pb_pin_i), .pb_out_o(pb_out_o), .pb_oe_n_o(pb_oe_n_o), .pb_pullup_o(pb_pullup_o),
    .pc_pin_i(pc_pin_i), .pc_out_o(pc_out_o), .pc_oe_n_o(pc_oe_n_o), .pc_pullup_o(pc_pullup_o)
  );

  // 250 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // implemented bits of each port
  function automatic logic [7:0] msk(input int p);
    return (p == 0) ? 8'hFF : (p == 1) ? 8'h0F : 8'h3F;
  endfunction

  // k: 0 pin input, 1 direction, 2 output data, 3 pull-up
  function automatic logic [5:0] ofs(input int p, input int k);
    logic [5:0] base;
    base = (p == 0) ? `GPR_OFS_PA_PIN : (p == 1) ? `GPR_OFS_PB_PIN : `GPR_OFS_PC_PIN;
    return base + k[5:0];
  endfunction

  // writable bits per address; unmapped places keep nothing
  function automatic logic [7:0] amask(input logic [5:0] a);
    case (a)
      `GPR_OFS_PA_DIR, `GPR_OFS_PA_DATA, `GPR_OFS_PA_PULLUP: return 8'hFF;
      `GPR_OFS_PB_DIR, `GPR_OFS_PB_DATA, `GPR_OFS_PB_PULLUP: return 8'h0F;
      `GPR_OFS_PC_DIR, `GPR_OFS_PC_DATA, `GPR_OFS_PC_PULLUP: return 8'h3F;
      `GPR_OFS_GUARD_CTRL: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction

  // pin registers toggle data when written, so random traffic skips them
  function automatic logic is_pin(input logic [5:0] a);
    return (a == `GPR_OFS_PA_PIN) || (a == `GPR_OFS_PB_PIN) || (a == `GPR_OFS_PC_PIN);
  endfunction

  // s: 0 output level, 1 enable (low drives), 2 pull-up
  function automatic logic [7:0] pout(input int p, input int s);
    case (p)
      0: return (s == 0) ? pa_out_o : (s == 1) ? pa_oe_n_o : pa_pullup_o;
      1: return {4'h0, (s == 0) ? pb_out_o : (s == 1) ? pb_oe_n_o : pb_pullup_o};
      default: return {2'h0, (s == 0) ? pc_out_o : (s == 1) ? pc_oe_n_o : pc_pullup_o};
    endcase
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp, "read data");
  endtask

  // write then read with no idle cycle between the two strobes
  task automatic wr_rd_chk(input logic [5:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp, "read after write");
  endtask

  task automatic set_pins(input int p, input logic [7:0] v);
    @(posedge clk_i);
    if (p == 0) pa_pin_i <= v;
    else if (p == 1) pb_pin_i <= v[3:0];
    else pc_pin_i <= v[5:0];
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short well beyond the few hundred cycles needed
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    int p, g, r, ai;
    logic [5:0] a;
    logic [7:0] d, u, m, pre, gb;
    rst_n_i = 1'b0;
    addr_i = 6'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pa_pin_i = 8'h00;
    pb_pin_i = 4'h0;
    pc_pin_i = 6'h00;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    // pins released and every register cleared after reset
    for (p = 0; p < 3; p++)
    begin
      chk(pout(p, 0), 8'h00, "reset out");
      chk(pout(p, 1), msk(p), "reset oe_n");
      chk(pout(p, 2), 8'h00, "reset pullup");
    end
    for (ai = 0; ai < 64; ai++)
    begin
      exp_reg[ai] = 8'h00;
      if (!is_pin(ai[5:0])) rd_chk(ai[5:0], 8'h00);
    end
    // random writes and read-backs, unmapped places included
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      a = r[5:0];
      if (is_pin(a)) a = a + 6'h01;
      r = $random(seed);
      d = r[7:0];
      wr(a, d);
      exp_reg[a] = d & amask(a);
      r = $random(seed);
      a = r[5:0];
      if (is_pin(a)) a = a + 6'h01;
      rd_chk(a, exp_reg[a]);
    end
    // data, direction and pull-up reach the pins, guard off
    wr(`GPR_OFS_GUARD_CTRL, 8'h00);
    for (p = 0; p < 3; p++)
    begin
      r = $random(seed);
      {d, u, m} = r[23:0];
      wr(ofs(p, 2), d);
      wr(ofs(p, 3), u);
      wr(ofs(p, 1), m);
      repeat (2) @(posedge clk_i);
      #1;
      chk(pout(p, 0), d & msk(p), "pin out");
      chk(pout(p, 1), ~m & msk(p), "pin oe_n");
      chk(pout(p, 2), u & ~m & msk(p), "pin pullup");
    end
    // pin levels show in the pin input registers after the synchroniser
    for (p = 0; p < 3; p++)
    begin
      r = $random(seed);
      set_pins(p, r[7:0]);
      repeat (3) @(posedge clk_i);
      rd_chk(ofs(p, 0), r[7:0] & msk(p));
    end
    // guard per port; other ports' guard bits must not delay this one
    for (p = 0; p < 3; p++)
    begin
      for (g = 0; g < 2; g++)
      begin
        gb = 8'h01 << p;
        wr(`GPR_OFS_GUARD_CTRL, (g == 1) ? (8'hF8 | gb) : (8'h07 & ~gb));
        rd_chk(`GPR_OFS_GUARD_CTRL, (g == 1) ? gb : (8'h07 & ~gb));
        pre = 8'h05 & msk(p);
        wr(ofs(p, 1), pre);
        repeat (3) @(posedge clk_i);
        wr(ofs(p, 1), 8'hFF);
        @(posedge clk_i);
        #1;
        // only the bits turning to output get the tri-state gap
        chk(pout(p, 1), (g == 1) ? (msk(p) & ~pre) : 8'h00, "gap cycle");
        @(posedge clk_i);
        #1;
        chk(pout(p, 1), 8'h00, "driving");
        wr(ofs(p, 1), 8'h00);
        @(posedge clk_i);
        #1;
        chk(pout(p, 1), msk(p), "released");
      end
    end
    // a one written to a pin register flips that output data bit
    for (p = 0; p < 3; p++)
    begin
      r = $random(seed);
      wr(ofs(p, 2), r[7:0]);
      wr(ofs(p, 0), r[15:8]);
      rd_chk(ofs(p, 2), (r[7:0] ^ r[15:8]) & msk(p));
      wr_rd_chk(ofs(p, 3), r[23:16], r[23:16] & msk(p));
    end
    // second reset with registers loaded and a pin driving
    wr(`GPR_OFS_PA_DIR, 8'hFF);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    for (p = 0; p < 3; p++)
    begin
      chk(pout(p, 0), 8'h00, "reset out");
      chk(pout(p, 1), msk(p), "reset oe_n");
      chk(pout(p, 2), 8'h00, "reset pullup");
      for (g = 1; g < 4; g++)
        rd_chk(ofs(p, g), 8'h00);
    end
    rd_chk(`GPR_OFS_GUARD_CTRL, 8'h00);
    end_sim();
  end
endmodule

`default_nettype wire
